// >>> adcreg_defines.svh
// Register offsets, field positions, reset values and timing counts for the converter register set.
// Assumes inclusion by the register module only.
`ifndef ADCREG_DEFINES_SVH
`define ADCREG_DEFINES_SVH

`define ADCREG_ADDR_STATUS      8'h00
`define ADCREG_ADDR_GENERAL     8'h01
`define ADCREG_ADDR_FORMAT      8'h02
`define ADCREG_ADDR_AVERAGE     8'h03
`define ADCREG_ADDR_OSC         8'h04

`define ADCREG_STATUS_RESET     8'h81
`define ADCREG_ZERO_RESET       8'h00

`define ADCREG_ST_ONE_BIT       7
`define ADCREG_ST_SEQ_BIT       6
`define ADCREG_ST_AVG_BIT       3
`define ADCREG_ST_CFG_BIT       2
`define ADCREG_ST_PWR_BIT       0

`define ADCREG_GEN_FORCE_BIT    2
`define ADCREG_GEN_CAL_BIT      1
`define ADCREG_GEN_RST_BIT      0

`define ADCREG_FMT_PAT_BIT      7
`define ADCREG_FMT_APP_HI       5
`define ADCREG_FMT_APP_LO       4
`define ADCREG_FMT_MODE_HI      1
`define ADCREG_FMT_MODE_LO      0

`define ADCREG_AVG_HI           2
`define ADCREG_OSCILLATOR_CHOICE_BIT      4
`define ADCREG_OSC_DIV_HI       3

`define ADCREG_TEST_PATTERN     12'hA5A
`define ADCREG_SOFT_RST_CYCLES  4'h4

`endif

// >>> adcreg_pkg.sv
// Types shared by the converter register set.
// Assumes the defines header is compiled alongside.
package adcreg_pkg;

    typedef enum logic [1:0] {
        ADCREG_IDLE  = 2'h0,
        ADCREG_RESET = 2'h1,
        ADCREG_DONE  = 2'h3
    } adcreg_rst_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcreg_req_t;

    typedef struct packed {
        logic       force_analog_all;
        logic       test_pattern_enable;
        logic [1:0] append_mode;
        logic [1:0] clock_mode;
        logic [2:0] average_count_select;
        logic       oscillator_choice;
        logic [3:0] clk_div;
        logic       cal_start;
    } adcreg_ctrl_t;

    typedef struct packed {
        logic              status_seq;
        logic              status_avg;
        logic              status_cfg;
        logic              status_pwr;
        logic              force_all;
        logic              cal_busy;
        logic              cal_pulse;
        logic [7:0]        fmt;
        logic [2:0]        avg;
        logic [4:0]        osc;
        logic [7:0]        rdata;
        logic              rvalid;
        adcreg_rst_state_t rst_state;
        logic [3:0]        rst_cnt;
    } adcreg_state_t;

endpackage : adcreg_pkg

// >>> adcreg_regs.sv
// Control and status register set of a small multi-channel converter.
// Assumes a serial-frame decoder upstream delivering one-cycle read/write strobes, all on clk_i.
`timescale 1ns/1ps
`include "adcreg_defines.svh"

// Function
// R1: Status bit 6 read-only, shows sequencer running.
// R2: Status bit 3 sets when averaging completes; write 1 clears.
// R3: Status bit 2 reports config CRC failure; sampled at reset only.
// R4: Status bit 0 resets to 1, sets on power loss; write 1 clears.
// R5: Reserved bits read zero, except status bit 7 reads one.
// R6: General bit 2 forces every channel to analog input.
// R7: General bit 1 starts offset calibration; self-clears when finished.
// R8: General bit 0 write-only soft reset; afterwards power-loss flag set.
// R9: Format bit 7 substitutes constant 0xA5A for conversion results.
// R10: Format bits 5-4 select channel id append; 10 and 11 reserved.
// R11: Format bits 1-0 select serial clock polarity and phase.
// R12: Averaging field bits 2-0 selects two to the code samples.
// R13: Oscillator register: select bit 4, divider bits 3-0, reset zero.
// R14: Oscillator select 0 high-speed, 1 low-power.
// R15: Sequencer steps to next enabled channel ascending, loops while running.
// R16: Writes to reserved or read-only bits ignored; others update.
module adcreg_regs (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire adcreg_pkg::adcreg_req_t req_i,
    input  wire logic                 seq_running_i,
    input  wire logic                 avg_done_i,
    input  wire logic                 cfg_crc_err_i,
    input  wire logic                 power_loss_i,
    input  wire logic                 cal_done_i,
    output logic [7:0]                rdata_o,
    output logic                      rvalid_o,
    output adcreg_pkg::adcreg_ctrl_t  ctrl_o,
    output logic                      soft_reset_busy_o
);

    adcreg_pkg::adcreg_state_t s_r;
    adcreg_pkg::adcreg_state_t s_nxt;

    logic wr_status;
    logic wr_general;
    logic wr_format;
    logic wr_average;
    logic wr_osc;

    assign wr_status  = req_i.wr && (req_i.addr == `ADCREG_ADDR_STATUS);
    assign wr_general = req_i.wr && (req_i.addr == `ADCREG_ADDR_GENERAL);
    assign wr_format  = req_i.wr && (req_i.addr == `ADCREG_ADDR_FORMAT);
    assign wr_average = req_i.wr && (req_i.addr == `ADCREG_ADDR_AVERAGE);
    assign wr_osc     = req_i.wr && (req_i.addr == `ADCREG_ADDR_OSC);

    always_comb begin
        s_nxt           = s_r;
        s_nxt.rvalid    = 1'b0;
        s_nxt.cal_pulse = 1'b0;
        // Sequencer state is a live mirror, never writable
        s_nxt.status_seq = seq_running_i;                                   // [R1] [R15]

        // Hardware set wins over a same-cycle write-one clear
        if (wr_status && req_i.wdata[`ADCREG_ST_AVG_BIT]) begin
            s_nxt.status_avg = 1'b0;                                        // [R2]
        end
        if (avg_done_i) begin
            s_nxt.status_avg = 1'b1;                                        // [R2]
        end
        if (wr_status && req_i.wdata[`ADCREG_ST_PWR_BIT]) begin
            s_nxt.status_pwr = 1'b0;                                        // [R4]
        end
        if (power_loss_i) begin
            s_nxt.status_pwr = 1'b1;                                        // [R4]
        end

        if (wr_general) begin
            s_nxt.force_all = req_i.wdata[`ADCREG_GEN_FORCE_BIT];           // [R6] [R16]
            if (req_i.wdata[`ADCREG_GEN_CAL_BIT] && !s_r.cal_busy) begin
                s_nxt.cal_busy  = 1'b1;                                     // [R7]
                s_nxt.cal_pulse = 1'b1;                                     // [R7]
            end
        end
        if (cal_done_i && s_r.cal_busy) begin
            s_nxt.cal_busy = 1'b0;                                          // [R7]
        end
        if (wr_format) begin
            s_nxt.fmt = req_i.wdata & 8'hB3;                                // [R9] [R10] [R11] [R16]
        end
        if (wr_average) begin
            s_nxt.avg = req_i.wdata[`ADCREG_AVG_HI:0];                      // [R12]
        end
        if (wr_osc) begin
            s_nxt.osc = req_i.wdata[`ADCREG_OSCILLATOR_CHOICE_BIT:0];                 // [R13] [R14]
        end

        if (req_i.rd) begin
            s_nxt.rvalid = 1'b1;
            unique case (req_i.addr)
                `ADCREG_ADDR_STATUS: s_nxt.rdata = {1'b1, s_r.status_seq, 2'h0, s_r.status_avg,
                                                    s_r.status_cfg, 1'b0, s_r.status_pwr};   // [R5]
                // Soft-reset bit is write-only and always reads zero
                `ADCREG_ADDR_GENERAL: s_nxt.rdata = {5'h00, s_r.force_all, s_r.cal_busy, 1'b0}; // [R8]
                `ADCREG_ADDR_FORMAT:  s_nxt.rdata = s_r.fmt;
                `ADCREG_ADDR_AVERAGE: s_nxt.rdata = {5'h00, s_r.avg};
                `ADCREG_ADDR_OSC:     s_nxt.rdata = {3'h0, s_r.osc};            // [R13]
                default:              s_nxt.rdata = 8'h00;
            endcase
        end

        unique case (s_r.rst_state)
            adcreg_pkg::ADCREG_IDLE: begin
                if (wr_general && req_i.wdata[`ADCREG_GEN_RST_BIT]) begin
                    s_nxt.rst_state = adcreg_pkg::ADCREG_RESET;             // [R8]
                    s_nxt.rst_cnt   = `ADCREG_SOFT_RST_CYCLES;
                end
            end
            adcreg_pkg::ADCREG_RESET: begin
                // Registers held at defaults while the sequence runs
                s_nxt.force_all = 1'b0;
                s_nxt.cal_busy  = 1'b0;
                s_nxt.fmt       = `ADCREG_ZERO_RESET;
                s_nxt.avg       = 3'h0;
                s_nxt.osc       = 5'h00;
                s_nxt.status_avg = 1'b0;
                s_nxt.status_cfg = cfg_crc_err_i;                           // [R3]
                s_nxt.rst_cnt   = s_r.rst_cnt - 4'h1;
                if (s_r.rst_cnt == 4'h1) begin
                    s_nxt.rst_state = adcreg_pkg::ADCREG_DONE;
                end
            end
            adcreg_pkg::ADCREG_DONE: begin
                s_nxt.status_pwr = 1'b1;                                    // [R8] [R4]
                s_nxt.rst_state  = adcreg_pkg::ADCREG_IDLE;
            end
            default: begin
                s_nxt.rst_state = adcreg_pkg::ADCREG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r            <= '0;
            s_r.status_pwr <= 1'b1;                                         // [R4]
            // Constant here; the CRC level is caught on the first edge after release
            s_r.rst_state  <= adcreg_pkg::ADCREG_RESET;                     // [R3]
            s_r.rst_cnt    <= 4'h1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o                        = s_r.rdata;
    assign rvalid_o                       = s_r.rvalid;
    assign ctrl_o.force_analog_all        = s_r.force_all;                  // [R6]
    assign ctrl_o.test_pattern_enable     = s_r.fmt[`ADCREG_FMT_PAT_BIT];   // [R9]
    assign ctrl_o.append_mode             = s_r.fmt[`ADCREG_FMT_APP_HI:`ADCREG_FMT_APP_LO]; // [R10]
    assign ctrl_o.clock_mode              = s_r.fmt[`ADCREG_FMT_MODE_HI:`ADCREG_FMT_MODE_LO]; // [R11]
    assign ctrl_o.average_count_select    = s_r.avg;                        // [R12]
    assign ctrl_o.oscillator_choice       = s_r.osc[`ADCREG_OSCILLATOR_CHOICE_BIT];   // [R14]
    assign ctrl_o.clk_div                 = s_r.osc[`ADCREG_OSC_DIV_HI:0];
    assign ctrl_o.cal_start               = s_r.cal_pulse;                  // [R7]
    // Low state bit is set in both busy states, so the flag leaves a flop directly
    assign soft_reset_busy_o              = s_r.rst_state[0];                // [R8]

endmodule : adcreg_regs

// >>> adcreg_sva.sv
// Port assertions for the converter register set.
// Assumes one clock domain; bound from the bench.
`timescale 1ns/1ps
module adcreg_sva (
    input wire logic                     clk_i,
    input wire logic                     rst_n_i,
    input wire adcreg_pkg::adcreg_req_t  req_i,
    input wire logic [7:0]               rdata_o,
    input wire logic                     rvalid_o,
    input wire adcreg_pkg::adcreg_ctrl_t ctrl_o,
    input wire logic                     soft_reset_busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic wr_ok;
    // Writes during soft reset may be overwritten
    assign wr_ok = req_i.wr && !soft_reset_busy_o;
    a_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("read unanswered");
    a_status_fixed: assert property (req_i.rd && req_i.addr == 8'h00 |=>
        rdata_o[7] && rdata_o[5:4] == 2'h0 && !rdata_o[1]) else $error("status fixed bits");
    a_fmt_write: assert property (wr_ok && req_i.addr == 8'h02 |=>
        {ctrl_o.test_pattern_enable, 1'b0, ctrl_o.append_mode, 2'h0, ctrl_o.clock_mode}
        == ($past(req_i.wdata) & 8'hB3)) else $error("format field");
    a_avg_write: assert property (wr_ok && req_i.addr == 8'h03 |=>
        {5'h00, ctrl_o.average_count_select} == ($past(req_i.wdata) & 8'h07)) else $error("averaging field");
    a_osc_write: assert property (wr_ok && req_i.addr == 8'h04 |=>
        {3'h0, ctrl_o.oscillator_choice, ctrl_o.clk_div} == ($past(req_i.wdata) & 8'h1F)) else $error("osc field");
    a_force_write: assert property (wr_ok && req_i.addr == 8'h01 && !req_i.wdata[0] |=>
        {5'h00, ctrl_o.force_analog_all, 2'h0} == ($past(req_i.wdata) & 8'h04)) else $error("force field");
    a_cal_pulse: assert property (ctrl_o.cal_start |->
        ($past(req_i.wr) && $past(req_i.addr) == 8'h01) ##1 !ctrl_o.cal_start)
        else $error("cal start pulse");
    a_soft_busy: assert property (wr_ok && req_i.addr == 8'h01 && req_i.wdata[0] |=>
        soft_reset_busy_o [*4]) else $error("soft reset too short");
endmodule : adcreg_sva

// >>> adcreg_host.sv
// Host model issuing one-byte register requests.
// Assumes the answer one cycle after the read strobe.
`timescale 1ns/1ps
module adcreg_host (
    input  wire logic               clk_i,
    output adcreg_pkg::adcreg_req_t req_o
);
    initial req_o = '0;
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic r);
        @(posedge clk_i);
        req_o <= '{addr: a, wdata: d, wr: !r, rd: r};
        @(posedge clk_i);
        req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0}; // Inverse, so stale data never passes
        #1;
    endtask : xfer
endmodule : adcreg_host

// >>> adcreg_regs_bench.sv
// Self-checking bench for the converter register set.
// Assumes 20 MHz clock and synchronous active-low reset.
`timescale 1ns/1ps
module adcreg_regs_bench;
    logic                     clk_i = 1'b0, rst_n_i = 1'b0, rvalid, busy;
    logic [4:0]               ev = 5'h00;
    logic [7:0]               rdata;
    adcreg_pkg::adcreg_req_t  req;
    adcreg_pkg::adcreg_ctrl_t ctrl;
    int                       miscompares = 0, tests_run = 0;
    logic [23:0]              rows [6] = '{24'h01FC04, 24'h02FFB3, 24'h024C00, 24'h03FF07, 24'h04FF1F, 24'h07FF00};
    always #25 clk_i = ~clk_i;
    adcreg_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .seq_running_i(ev[4]), .avg_done_i(ev[1]),
        .cfg_crc_err_i(ev[3]), .power_loss_i(ev[0]), .cal_done_i(ev[2]), .rdata_o(rdata), .rvalid_o(rvalid),
        .ctrl_o(ctrl), .soft_reset_busy_o(busy));
    adcreg_host host (.clk_i(clk_i), .req_o(req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) miscompares++;
        if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.xfer(a, 8'h00, 1'b1);
        chk({7'h00, rvalid, rdata}, {7'h00, 1'b1, exp});
    endtask : rchk
    // Bits 4:3 are levels, 2:0 are one-shot events
    task automatic kick(input logic [4:0] m);
        @(posedge clk_i);
        ev <= ev ^ m;
        @(posedge clk_i);
        ev <= ev ^ (m & 5'h07);
    endtask : kick
    task automatic idle();
        for (int n = 0; n < 20 && busy !== 1'b0; n++) @(negedge clk_i);
        chk({15'h0000, busy}, 16'h0000);
        if (busy !== 1'b0) end_of_test();
    endtask : idle
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        idle();
        chk(16'(ctrl), 16'h0000);
        rchk(8'h00, 8'h81);
        foreach (rows[k]) begin
            host.xfer(rows[k][23:16], rows[k][15:8], 1'b0);
            rchk(rows[k][23:16], rows[k][7:0]);
        end
        for (int i = 0; i < 8; i++) begin
            host.xfer(8'h03, 8'(i), 1'b0);
            host.xfer(8'h02, {2'h0, 2'(i), 2'h0, 2'(i)}, 1'b0);
            chk(16'(ctrl[12:6]), 16'({2'(i), 2'(i), 3'(i)}));
        end
        host.xfer(8'h00, 8'hFF, 1'b0);
        rchk(8'h00, 8'h80);
        kick(5'h12);
        rchk(8'h00, 8'hC8);
        kick(5'h11);
        rchk(8'h00, 8'h89);
        host.xfer(8'h00, 8'h09, 1'b0);
        rchk(8'h00, 8'h80);
        host.xfer(8'h01, 8'h06, 1'b0);
        chk(16'({ctrl.force_analog_all, ctrl.cal_start}), 16'h0003);
        rchk(8'h01, 8'h06);
        // Second start while busy must be refused
        host.xfer(8'h01, 8'h06, 1'b0);
        chk(16'(ctrl.cal_start), 16'h0000);
        kick(5'h04);
        rchk(8'h01, 8'h04);
        kick(5'h08);
        rchk(8'h00, 8'h80);
        host.xfer(8'h01, 8'h01, 1'b0);
        idle();
        rchk(8'h00, 8'h85);
        rchk(8'h02, 8'h00);
        end_of_test();
    end
endmodule : adcreg_regs_bench
bind adcreg_regs adcreg_sva sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .soft_reset_busy_o(soft_reset_busy_o));
